// ### common/chg_map.svh
// Register map and bit layout constants for the charger register bank.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef CHG_MAP_SVH
`define CHG_MAP_SVH

// ============================================================
// Bus addressing
`define CHG_DEV_ADDR        7'h6A
`define CHG_ADDR_ICL        8'h00
`define CHG_ADDR_LAST       8'h0C
`define CHG_ADDR_STAT0      8'h08
`define CHG_ADDR_STAT1      8'h09
`define CHG_ADDR_STAT2      8'h0A
`define CHG_ADDR_PART       8'h0B
`define CHG_UNMAPPED_DATA   8'hFF

// ============================================================
// Reset values
`define CHG_INPUT_CURRENT_LIMIT_RST       8'h17
`define CHG_CHARGER_CONTROL_0_RST       8'h1A
`define CHG_CHARGE_CURRENT_LIMIT_RST       8'h91
`define CHG_REGXX_RST       8'h00

// ============================================================
// Input current limit register layout
`define CHG_BIT_HIZ         7
`define CHG_BIT_TS_OVR      6
`define CHG_BIT_SNS_DIS     5
`define CHG_ICL_MSB         4
`define CHG_ICL_PSEL_HI     5'h04
`define CHG_ICL_PSEL_LO     5'h17
`define CHG_NTC_NORMAL      3'h0

// ============================================================
// Serial engine and storage
`define CHG_BIT_LAST        3'h7
`define CHG_BIT_FIRST       3'h0
`define CHG_MEM_DEPTH       16
`define CHG_MEM_AW          4

`endif

// ### common/chg_pkg.sv
// Types shared by the charger register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package chg_pkg;

    // ============================================================
    // Serial target states
    typedef enum logic [3:0] {
        CHG_ST_IDLE     = 4'h0,
        CHG_ST_DEV_ADDR = 4'h1,
        CHG_ST_DEV_ACK  = 4'h2,
        CHG_ST_REG_ADDR = 4'h3,
        CHG_ST_REG_ACK  = 4'h4,
        CHG_ST_WR_DATA  = 4'h5,
        CHG_ST_WR_ACK   = 4'h6,
        CHG_ST_RD_DATA  = 4'h7,
        CHG_ST_RD_ACK   = 4'h8
    } chg_state_t;

endpackage : chg_pkg

// ### core/chg_regmem.sv
// Byte storage for the plain read/write control registers.
// Assumes one synchronous clock; clr_n is a synchronous active-low clear.
`include "chg_map.svh"

module chg_regmem (
    input  wire logic                     clk,
    input  wire logic                     clr_n,
    input  wire logic                     we,
    input  wire logic [`CHG_MEM_AW-1:0]   waddr,
    input  wire logic [7:0]               wdata,
    input  wire logic [`CHG_MEM_AW-1:0]   raddr,
    output logic      [7:0]               rdata
);

    logic [7:0] word_q [`CHG_MEM_DEPTH];

    function automatic logic [7:0] rst_value(input int idx);
        logic [7:0] v;
        v = `CHG_REGXX_RST;
        if (idx == 1) v = `CHG_CHARGER_CONTROL_0_RST;
        if (idx == 2) v = `CHG_CHARGE_CURRENT_LIMIT_RST;
        return v;
    endfunction : rst_value

    // ============================================================
    // One flop row per word so each can carry its own reset value
    for (genvar i = 0; i < `CHG_MEM_DEPTH; i++) begin : g_word
        always_ff @(posedge clk) begin
            if (!clr_n) begin
                word_q[i] <= rst_value(i);
            end else if (we && (waddr == `CHG_MEM_AW'(i))) begin
                word_q[i] <= wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!clr_n) begin
            rdata <= `CHG_REGXX_RST;
        end else begin
            rdata <= word_q[raddr];
        end
    end

endmodule : chg_regmem

// ### core/chg_i2c_regs.sv
// Charger register bank reached as a serial two-wire target.
// Assumes scl_in/sda_in already synchronous to clk, which runs far above the bit rate.
// The sda pad is open drain: the bench resolves the wire from sda_oe_n.
`include "chg_map.svh"

// Contract
// RQ1 - Answer as target at seven-bit address 6Ah, then direction bit.
// RQ2 - Offsets 00h-0Ch exist; 00h-07h, 0Ch writable; 08h-0Bh read only.
// RQ3 - Input current limit register resets to 17h, all bits read/write.
// RQ4 - Bit 7 enables high impedance; cleared by register reset and watchdog.
// RQ5 - Bit 6 forces temperature sense good and reports thermistor field 000.
// RQ6 - Bit 5 low uses remote sense pin; high uses battery pin.
// RQ7 - With remote sense selected, fall back to battery pin on sense failure.
// RQ8 - Bits 4:0 are limit code, 100 mA step; reset only by register reset.
// RQ9 - Default limit code is 10111, meaning 2400 mA.
// RQ10 - Source detection done loads 500 mA if select high, 2.4 A if low.
// RQ11 - Host writes its own limit only after source detection completes.
// RQ12 - Reading any offset above 0Ch returns FFh.
// RQ13 - Undefined register address gets not-acknowledge and return to idle.
// RQ14 - Writes to read-only offsets are acknowledged and change nothing.
module chg_i2c_regs (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       reg_reset,
    input  wire logic       watchdog_expired,
    input  wire logic       source_detect_done,
    input  wire logic       power_select_pin,
    input  wire logic       remote_sense_fail_flag,
    input  wire logic       temp_sense_pin_good,
    input  wire logic [2:0] thermistor_fault_raw,
    input  wire logic [7:0] status_0,
    input  wire logic [7:0] status_1,
    input  wire logic [7:0] status_2,
    input  wire logic [7:0] part_info,
    output logic            high_impedance_enable,
    output logic            temp_sense_ok,
    output logic [2:0]      thermistor_fault_field,
    output logic            use_battery_pin,
    output logic [4:0]      input_current_limit_code
);

    // ============================================================
    // Pin sampling and bus events
    logic scl_q, sda_q, scl_prev_q, sda_prev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_q      <= scl_in;
            sda_q      <= sda_in;
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    wire start_det = scl_q && scl_prev_q && sda_prev_q && !sda_q;
    wire stop_det  = scl_q && scl_prev_q && !sda_prev_q && sda_q;
    wire scl_rise  = scl_q && !scl_prev_q;
    wire scl_fall  = !scl_q && scl_prev_q;

    // ============================================================
    // Address decoding
    function automatic logic is_read_only(input logic [7:0] a);
        return (a >= `CHG_ADDR_STAT0) && (a <= `CHG_ADDR_PART);
    endfunction : is_read_only

    function automatic logic is_defined(input logic [7:0] a);
        return a <= `CHG_ADDR_LAST;
    endfunction : is_defined

    chg_pkg::chg_state_t state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] ptr_q, ptr_d;
    logic [2:0] bit_cnt_q, bit_cnt_d;
    logic       byte_done_q, byte_done_d;
    logic       drive_q, drive_d;
    logic       rw_q, rw_d;
    logic       host_ack_q, host_ack_d;
    logic       wr_commit;
    logic [7:0] input_current_limit_q, input_current_limit_d;
    logic [7:0] mem_rdata;
    logic [7:0] rd_byte;

    wire addr_match = shift_q[7:1] == `CHG_DEV_ADDR;
    wire ptr_ok     = is_defined(ptr_q);
    wire icl_wr     = wr_commit && (ptr_q == `CHG_ADDR_ICL);
    wire mem_we     = wr_commit && (ptr_q != `CHG_ADDR_ICL) && !is_read_only(ptr_q); // [RQ14]
    wire rx_state   = (state_q == chg_pkg::CHG_ST_DEV_ADDR) ||
                      (state_q == chg_pkg::CHG_ST_REG_ADDR) ||
                      (state_q == chg_pkg::CHG_ST_WR_DATA);

    // Status and identity bytes come straight from the analog side
    assign rd_byte = !ptr_ok                      ? `CHG_UNMAPPED_DATA : // [RQ12]
                     (ptr_q == `CHG_ADDR_ICL)   ? input_current_limit_q   :
                     (ptr_q == `CHG_ADDR_STAT0) ? status_0  :
                     (ptr_q == `CHG_ADDR_STAT1) ? status_1  :
                     (ptr_q == `CHG_ADDR_STAT2) ? status_2  :
                     (ptr_q == `CHG_ADDR_PART)  ? part_info : mem_rdata; // [RQ2]

    // ============================================================
    // Serial target sequencing
    always_comb begin
        state_d     = state_q;
        shift_d     = shift_q;
        ptr_d       = ptr_q;
        bit_cnt_d   = bit_cnt_q;
        byte_done_d = byte_done_q;
        drive_d     = drive_q;
        rw_d        = rw_q;
        host_ack_d  = host_ack_q;
        wr_commit   = 1'b0;
        if (start_det) begin
            state_d     = chg_pkg::CHG_ST_DEV_ADDR;
            bit_cnt_d   = `CHG_BIT_FIRST;
            byte_done_d = 1'b0;
            drive_d     = 1'b0;
        end else if (stop_det) begin
            state_d     = chg_pkg::CHG_ST_IDLE;
            drive_d     = 1'b0;
        end else if (scl_rise) begin
            if (rx_state) begin
                shift_d = {shift_q[6:0], sda_q};
            end
            if (rx_state || state_q == chg_pkg::CHG_ST_RD_DATA) begin
                bit_cnt_d   = bit_cnt_q + 3'h1;
                byte_done_d = bit_cnt_q == `CHG_BIT_LAST;
            end
            if (state_q == chg_pkg::CHG_ST_RD_ACK) begin
                host_ack_d = !sda_q;
            end
        end else if (scl_fall) begin
            unique case (state_q)
                chg_pkg::CHG_ST_IDLE: begin
                end
                chg_pkg::CHG_ST_DEV_ADDR: begin
                    if (byte_done_q) begin
                        byte_done_d = 1'b0;
                        if (addr_match) begin // [RQ1]
                            state_d = chg_pkg::CHG_ST_DEV_ACK;
                            drive_d = 1'b1;
                            rw_d    = shift_q[0];
                        end else begin
                            state_d = chg_pkg::CHG_ST_IDLE;
                        end
                    end
                end
                chg_pkg::CHG_ST_DEV_ACK, chg_pkg::CHG_ST_RD_ACK: begin
                    bit_cnt_d = `CHG_BIT_FIRST;
                    if ((state_q == chg_pkg::CHG_ST_DEV_ACK && rw_q) ||
                        (state_q == chg_pkg::CHG_ST_RD_ACK && host_ack_q)) begin
                        state_d = chg_pkg::CHG_ST_RD_DATA;
                        shift_d = {rd_byte[6:0], 1'b0};
                        drive_d = !rd_byte[7];
                        ptr_d   = ptr_q + 8'h01;
                    end else if (state_q == chg_pkg::CHG_ST_DEV_ACK) begin
                        state_d = chg_pkg::CHG_ST_REG_ADDR;
                        drive_d = 1'b0;
                    end else begin
                        state_d = chg_pkg::CHG_ST_IDLE;
                        drive_d = 1'b0;
                    end
                end
                chg_pkg::CHG_ST_REG_ADDR: begin
                    if (byte_done_q) begin
                        byte_done_d = 1'b0;
                        ptr_d       = shift_q;
                        if (is_defined(shift_q)) begin
                            state_d = chg_pkg::CHG_ST_REG_ACK;
                            drive_d = 1'b1;
                        end else begin
                            state_d = chg_pkg::CHG_ST_IDLE; // [RQ13]
                        end
                    end
                end
                chg_pkg::CHG_ST_REG_ACK, chg_pkg::CHG_ST_WR_ACK: begin
                    drive_d   = 1'b0;
                    bit_cnt_d = `CHG_BIT_FIRST;
                    state_d   = chg_pkg::CHG_ST_WR_DATA;
                    if (state_q == chg_pkg::CHG_ST_WR_ACK) begin
                        ptr_d = ptr_q + 8'h01;
                    end
                end
                chg_pkg::CHG_ST_WR_DATA: begin
                    if (byte_done_q) begin
                        byte_done_d = 1'b0;
                        if (ptr_ok) begin // [RQ2]
                            wr_commit = 1'b1;
                            drive_d   = 1'b1;
                            state_d   = chg_pkg::CHG_ST_WR_ACK;
                        end else begin
                            state_d   = chg_pkg::CHG_ST_IDLE; // [RQ13]
                        end
                    end
                end
                chg_pkg::CHG_ST_RD_DATA: begin
                    if (byte_done_q) begin
                        byte_done_d = 1'b0;
                        drive_d     = 1'b0;
                        state_d     = chg_pkg::CHG_ST_RD_ACK;
                    end else begin
                        drive_d = !shift_q[7];
                        shift_d = {shift_q[6:0], 1'b0};
                    end
                end
                default: begin
                    state_d = chg_pkg::CHG_ST_IDLE;
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q     <= chg_pkg::CHG_ST_IDLE;
            shift_q     <= `CHG_REGXX_RST;
            ptr_q       <= `CHG_ADDR_ICL;
            bit_cnt_q   <= `CHG_BIT_FIRST;
            byte_done_q <= 1'b0;
            drive_q     <= 1'b0;
            rw_q        <= 1'b0;
            host_ack_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            shift_q     <= shift_d;
            ptr_q       <= ptr_d;
            bit_cnt_q   <= bit_cnt_d;
            byte_done_q <= byte_done_d;
            drive_q     <= drive_d;
            rw_q        <= rw_d;
            host_ack_q  <= host_ack_d;
        end
    end

    // Open drain: only ever pull low
    assign sda_out  = 1'b0;
    assign sda_oe_n = !drive_q;

    // ============================================================
    // Input current limit register
    // Detection result beats a host write in the same cycle, so an early
    // host value is lost; the host is expected to wait for detection [RQ11]
    always_comb begin
        input_current_limit_d = icl_wr ? shift_q : input_current_limit_q; // [RQ3]
        if (watchdog_expired) begin
            input_current_limit_d[`CHG_BIT_HIZ] = 1'b0; // [RQ4]
        end
        if (source_detect_done) begin
            input_current_limit_d[`CHG_ICL_MSB:0] = power_select_pin ? `CHG_ICL_PSEL_HI
                                                       : `CHG_ICL_PSEL_LO; // [RQ10]
        end
        if (reg_reset) begin
            input_current_limit_d = `CHG_INPUT_CURRENT_LIMIT_RST; // [RQ8] [RQ9]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_current_limit_q <= `CHG_INPUT_CURRENT_LIMIT_RST; // [RQ3] [RQ9]
        end else begin
            input_current_limit_q <= input_current_limit_d;
        end
    end

    // ============================================================
    // Other control bytes
    chg_regmem u_regmem (
        .clk   (clk),
        .clr_n (rst_n && !reg_reset),
        .we    (mem_we),
        .waddr (ptr_q[`CHG_MEM_AW-1:0]),
        .wdata (shift_q),
        .raddr (ptr_q[`CHG_MEM_AW-1:0]),
        .rdata (mem_rdata)
    );

    // ============================================================
    // Analog-facing controls
    logic       ts_ok_q, bat_pin_q;
    logic [2:0] ntc_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ts_ok_q   <= 1'b0;
            bat_pin_q <= 1'b0;
            ntc_q     <= `CHG_NTC_NORMAL;
        end else begin
            ts_ok_q   <= input_current_limit_q[`CHG_BIT_TS_OVR] || temp_sense_pin_good; // [RQ5]
            ntc_q     <= input_current_limit_q[`CHG_BIT_TS_OVR] ? `CHG_NTC_NORMAL
                                                  : thermistor_fault_raw; // [RQ5]
            // Sense failure forces the battery pin even if remote sense chosen
            bat_pin_q <= input_current_limit_q[`CHG_BIT_SNS_DIS] || remote_sense_fail_flag; // [RQ6] [RQ7]
        end
    end

    assign high_impedance_enable    = input_current_limit_q[`CHG_BIT_HIZ]; // [RQ4]
    assign temp_sense_ok            = ts_ok_q;
    assign thermistor_fault_field   = ntc_q;
    assign use_battery_pin          = bat_pin_q;
    assign input_current_limit_code = input_current_limit_q[`CHG_ICL_MSB:0]; // [RQ8]

    // ============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_addr_byte_done;
        state_q == chg_pkg::CHG_ST_DEV_ADDR && byte_done_q && scl_fall && !start_det;
    endsequence
    sequence s_bad_reg_addr;
        state_q == chg_pkg::CHG_ST_REG_ADDR && byte_done_q && scl_fall && !start_det &&
            !stop_det && !is_defined(shift_q);
    endsequence

    a_addr_ack_match: assert property (s_addr_byte_done ##0 addr_match |=> // [RQ1]
        state_q == chg_pkg::CHG_ST_DEV_ACK && !sda_oe_n)
        else $error("matching target address not acknowledged");
    a_ro_write_keep: assert property (wr_commit && is_read_only(ptr_q) |-> // [RQ14]
        !mem_we && !icl_wr ##1 !sda_oe_n)
        else $error("read-only write not acknowledged or stored");
    a_reset_value_icl: assert property (!$past(rst_n) |-> input_current_limit_q == `CHG_INPUT_CURRENT_LIMIT_RST) // [RQ3]
        else $error("input limit register reset value wrong");
    a_hiz_watchdog_clr: assert property (watchdog_expired && !reg_reset |=> // [RQ4]
        !high_impedance_enable)
        else $error("watchdog did not clear high impedance");
    a_temp_override_ok: assert property (input_current_limit_q[`CHG_BIT_TS_OVR] |=> // [RQ5]
        temp_sense_ok && thermistor_fault_field == `CHG_NTC_NORMAL)
        else $error("temperature override not applied");
    a_fb_pin_select: assert property (!input_current_limit_q[`CHG_BIT_SNS_DIS] && // [RQ7]
        !remote_sense_fail_flag |=> !use_battery_pin)
        else $error("remote sense not selected");
    a_fb_fallback: assert property ((input_current_limit_q[`CHG_BIT_SNS_DIS] || // [RQ6]
        remote_sense_fail_flag) |=> use_battery_pin)
        else $error("battery pin not used");
    a_reg_reset_icl: assert property (reg_reset |=> // [RQ8]
        input_current_limit_code == `CHG_ICL_PSEL_LO && !high_impedance_enable)
        else $error("register reset did not restore limit");
    a_detect_update: assert property (source_detect_done && !reg_reset |=> // [RQ10]
        input_current_limit_code == ($past(power_select_pin) ? `CHG_ICL_PSEL_HI
                                                              : `CHG_ICL_PSEL_LO))
        else $error("detection result not loaded");
    a_unmapped_ff: assert property (!is_defined(ptr_q) |-> // [RQ12]
        rd_byte == `CHG_UNMAPPED_DATA)
        else $error("unmapped read not FFh");
    a_bad_addr_nack: assert property (s_bad_reg_addr |=> // [RQ13]
        state_q == chg_pkg::CHG_ST_IDLE && sda_oe_n [*2])
        else $error("undefined register not refused");

endmodule : chg_i2c_regs

// ### dv/chg_host_model.sv
// Host controller model that drives the charger two-wire port.
// Assumes the bench resolves sda from both pull-downs plus a pull-up.
module chg_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // ============================================================
    // Bit level
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    function automatic logic [7:0] dev(input logic rw);
        return {7'h6A, rw};
    endfunction : dev

    // Data moves two cycles into the low phase so no change lines up with an SCL fall
    task automatic bit_io(input logic o, output logic i);
        sda_low <= ~o;
        cyc(3);
        scl <= 1'b1;
        cyc(5);
        i = sda;
        scl <= 1'b0;
        cyc(2);
    endtask : bit_io

    // ============================================================
    // Framing and bytes
    task automatic start();
        sda_low <= 1'b0;
        cyc(3);
        scl <= 1'b1;
        cyc(3);
        sda_low <= 1'b1;
        cyc(3);
        scl <= 1'b0;
        cyc(2);
    endtask : start

    task automatic stop();
        sda_low <= 1'b1;
        cyc(3);
        scl <= 1'b1;
        cyc(3);
        sda_low <= 1'b0;
        cyc(5);
    endtask : stop

    task automatic wr(input logic [7:0] b, output logic ack);
        logic x;
        for (int k = 7; k >= 0; k--) begin
            bit_io(b[k], x);
        end
        bit_io(1'b1, x);
        ack = ~x;
    endtask : wr

    // Last byte is refused so the target lets go of the wire
    task automatic rd(input logic last, output logic [7:0] b);
        logic x;
        for (int k = 7; k >= 0; k--) begin
            bit_io(1'b1, x);
            b[k] = x;
        end
        bit_io(last, x);
    endtask : rd
endmodule : chg_host_model

// ### dv/charger_i2c_register_map_tb.sv
// Self-checking bench for the charger register bank.
// Assumes the host model in dv/ and a pull-up on the data wire.
module charger_i2c_register_map_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, rst_n, reg_reset, watchdog_expired, source_detect_done;
    logic       power_select_pin, remote_sense_fail_flag, temp_sense_pin_good;
    logic [2:0] thermistor_fault_raw, thermistor_fault_field;
    logic       sda_out, sda_oe_n, high_impedance_enable, temp_sense_ok, use_battery_pin;
    logic [4:0] input_current_limit_code;
    logic       scl, sda_low;
    logic [7:0] stat_v [4];
    int         error_cnt, n_tests;
    // Offset, byte written, byte read back
    logic [23:0] rows [9] = '{24'h00A5A5, 24'h013C3C, 24'h02C3C3, 24'h078181,
        24'h0C5A5A, 24'h08FF11, 24'h090022, 24'h0A5533, 24'h0BAA44};
    wire        sda = (sda_oe_n === 1'b0 || sda_low) ? 1'b0 : 1'b1;

    chg_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

    chg_i2c_regs dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reg_reset(reg_reset),
        .watchdog_expired(watchdog_expired), .source_detect_done(source_detect_done),
        .power_select_pin(power_select_pin), .remote_sense_fail_flag(remote_sense_fail_flag),
        .temp_sense_pin_good(temp_sense_pin_good), .thermistor_fault_raw(thermistor_fault_raw),
        .status_0(stat_v[0]), .status_1(stat_v[1]), .status_2(stat_v[2]),
        .part_info(stat_v[3]),
        .high_impedance_enable(high_impedance_enable), .temp_sense_ok(temp_sense_ok),
        .thermistor_fault_field(thermistor_fault_field), .use_battery_pin(use_battery_pin),
        .input_current_limit_code(input_current_limit_code));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ============================================================
    // Shared tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [7:0] d, output logic [2:0] k);
        host.start();
        host.wr(host.dev(1'b0), k[2]);
        host.wr(a, k[1]);
        host.wr(d, k[0]);
        host.stop();
    endtask : wreg

    task automatic rreg(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
        logic x;
        host.start();
        host.wr(host.dev(1'b0), x);
        host.wr(a, x);
        host.start();
        host.wr(host.dev(1'b1), x);
        host.rd(1'b0, d0);
        host.rd(1'b1, d1);
        host.stop();
    endtask : rreg

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        summarize();
    end

    // ============================================================
    // Main sequence
    initial begin
        logic [2:0] k;
        logic [7:0] d0, d1;
        rst_n = 1'b0;
        reg_reset = 1'b0;
        watchdog_expired = 1'b0;
        source_detect_done = 1'b0;
        power_select_pin = 1'b0;
        remote_sense_fail_flag = 1'b0;
        temp_sense_pin_good = 1'b0;
        thermistor_fault_raw = 3'h5;
        stat_v = '{8'h11, 8'h22, 8'h33, 8'h44};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        host.cyc(4);
        chk("code", 8'h17, 8'(input_current_limit_code));
        chk("hiz", 8'h00, 8'(high_impedance_enable));
        foreach (rows[i]) begin
            wreg(rows[i][23:16], rows[i][15:8], k);
            chk("ack", 8'h07, 8'(k));
            rreg(rows[i][23:16], d0, d1);
            chk("read", rows[i][7:0], d0);
        end
        wreg(8'h00, 8'hDF, k);
        chk("hiz", 8'h01, 8'(high_impedance_enable));
        chk("tok", 8'h01, 8'(temp_sense_ok));
        chk("ntc", 8'h00, 8'(thermistor_fault_field));
        chk("bat", 8'h00, 8'(use_battery_pin));
        chk("code", 8'h1F, 8'(input_current_limit_code));
        wreg(8'h00, 8'h20, k);
        chk("tok", 8'h00, 8'(temp_sense_ok));
        chk("ntc", 8'h05, 8'(thermistor_fault_field));
        chk("bat", 8'h01, 8'(use_battery_pin));
        chk("code", 8'h00, 8'(input_current_limit_code));
        temp_sense_pin_good <= 1'b1;
        thermistor_fault_raw <= 3'h2;
        stat_v[0] <= 8'h66;
        host.cyc(3);
        chk("tok", 8'h01, 8'(temp_sense_ok));
        chk("ntc", 8'h02, 8'(thermistor_fault_field));
        rreg(8'h08, d0, d1);
        chk("stat", 8'h66, d0);
        temp_sense_pin_good <= 1'b0;
        wreg(8'h00, 8'h00, k);
        remote_sense_fail_flag <= 1'b1;
        host.cyc(3);
        chk("bat", 8'h01, 8'(use_battery_pin));
        remote_sense_fail_flag <= 1'b0;
        host.cyc(3);
        chk("bat", 8'h00, 8'(use_battery_pin));
        wreg(8'h00, 8'h9A, k);
        watchdog_expired <= 1'b1;
        host.cyc(1);
        watchdog_expired <= 1'b0;
        host.cyc(3);
        chk("hiz", 8'h00, 8'(high_impedance_enable));
        rreg(8'h00, d0, d1);
        chk("wdog", 8'h1A, d0);
        power_select_pin <= 1'b1;
        source_detect_done <= 1'b1;
        host.cyc(1);
        source_detect_done <= 1'b0;
        host.cyc(3);
        chk("code", 8'h04, 8'(input_current_limit_code));
        power_select_pin <= 1'b0;
        source_detect_done <= 1'b1;
        host.cyc(1);
        source_detect_done <= 1'b0;
        host.cyc(3);
        chk("code", 8'h17, 8'(input_current_limit_code));
        // Host limit goes in only once detection is over
        wreg(8'h00, 8'hE3, k);
        rreg(8'h00, d0, d1);
        chk("host", 8'hE3, d0);
        reg_reset <= 1'b1;
        host.cyc(1);
        reg_reset <= 1'b0;
        host.cyc(3);
        chk("hiz", 8'h00, 8'(high_impedance_enable));
        rreg(8'h00, d0, d1);
        chk("r00", 8'h17, d0);
        chk("r01", 8'h1A, d1);
        wreg(8'h0D, 8'h11, k);
        chk("nack", 8'h04, 8'(k));
        rreg(8'h0C, d0, d1);
        chk("past", 8'hFF, d1);
        host.start();
        host.wr(8'hAA, k[0]);
        host.stop();
        chk("other", 8'h00, 8'(k[0]));
        rreg(8'h00, d0, d1);
        chk("again", 8'h17, d0);
        summarize();
    end
endmodule : charger_i2c_register_map_tb
